// ### inc/crane_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CRANE_REGS_SVH
`define CRANE_REGS_SVH

// Timing: figures in their own unit, cycle counts derived from the clock rate
`define CLK_HZ 25000000
`define TICK_MS 1
`define REF_UPD_MS 32
`define TRIM_UPD_MS 8
`define MS_CYC(ms) ((`CLK_HZ / 1000) * (ms))

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_DEADZONE 8'h04
`define OFS_AOFFSET 8'h08
`define OFS_REDUCED 8'h0C
`define OFS_LIMITS 8'h10
`define OFS_TRQMAX 8'h14
`define OFS_DELAYS 8'h18
`define OFS_FLUXOFF 8'h1C
`define OFS_FBTRIM 8'h20
`define OFS_STATUS 8'h24
`define OFS_REFS 8'h28

// Control register fields
`define F_SA 0
`define F_SPLIT 1
`define F_REGSEL 3:2
`define F_FSTYPE 5:4
`define F_SHAPE 14:8

// Reset values
`define RST_CTRL 32'h00000010
`define RST_DEADZONE 32'h01F401F4
`define RST_AOFFSET 32'h00000000
`define RST_REDUCED 32'h000007D0
`define RST_LIMITS 32'hD8F02710
`define RST_TRQMAX 32'h00002710
`define RST_DELAYS 32'h012C01F4
`define RST_FLUXOFF 32'h000003E8
`define RST_FBTRIM 32'h00000000

// Analog scaling: 12-bit codes, full scale is 10 V or 20 mA
`define AIN_FULL 12'hFFF
`define AIN_1V 12'h199
`define AIN_2MA 12'h199
`define PCT_FULL 32'h00002710
`define SHAPE_SQ 7'h14
`define SHAPE_CU 7'h64
`define TRIM_SHIFT 11

`endif

// ### inc/crane_pkg.sv
// Types shared by the stand-alone crane control design
package crane_pkg;

  typedef logic signed [15:0] vel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_MAGN = 2'h1,
    ST_RUN = 2'h2,
    ST_OFFD = 2'h3
  } run_state_e;

  typedef enum logic [1:0] {
    RM_SPEED = 2'h0,
    RM_TORQ = 2'h1,
    RM_COMB = 2'h2
  } regulation_select_e;

  typedef enum logic [1:0] {
    FS_TLIM = 2'h1,
    FS_TLIM_MECH = 2'h2,
    FS_MECH = 2'h3
  } fs_type_e;

  typedef struct packed {
    logic zero_pos;
    logic dir_a;
    logic dir_b;
  } joy_s;

  typedef struct packed {
    logic fast_zero_set;
    logic speed_off;
    logic fast_stop;
  } fs_out_s;

  typedef struct packed {
    logic link_comm_fault;
    logic ms_link_fault;
    logic brake_long_fall;
    logic chopper_fault;
    logic cpu_stall;
  } fault_s;

endpackage : crane_pkg

// ### design/hold_timer.sv
// Hold timer: reports a condition held longer than a limit in ms ticks
`timescale 1ns/100ps
module hold_timer #(
  parameter int CNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic cond,
  input wire logic [CNT_W-1:0] limit,
  output logic done
);

  logic [CNT_W:0] cnt;

  if (CNT_W < 2) begin : g_chk
    $error("hold_timer: CNT_W too small");
  end

  // Any gap in the condition restarts the count, so only unbroken spells qualify
  always_ff @(posedge aclk) begin
    if (!aresetn || !cond) begin
      cnt <= '0;
      done <= 1'b0;
    end else begin
      if (tick && !cnt[CNT_W]) begin
        cnt <= cnt + 1'b1;
      end
      done <= cnt > {1'b0, limit}; // Strictly longer than the limit
    end
  end

  property p_done_needs_cond;
    @(posedge aclk) disable iff (!aresetn) !cond |=> !done;
  endproperty
  a_done_needs_cond: assert property (p_done_needs_cond) else $error("done without condition");

endmodule : hold_timer

// ### design/crane_joystick_standalone_ctrl.sv
// Stand-alone crane joystick control: interlocks, references, fast stop, health
`timescale 1ns/100ps
`include "crane_regs.svh"
// Summary of operation
// - Starts, references and fast stop act only with stand-alone selected
// - Speed 0-10V, torque 0-20mA scaled to references
// - Direction A positive, direction B negative
// - Offset level of speed input means zero
// - Separate deadzone per direction
// - Shape 0 linear, 20 square, 100 cubic
// - Both directions too long: fault, stop, warn
// - Neutral with analog above 1V/2mA: fault
// - Fault blocks starts until neutral held
// - Start on one direction, magnetise, then ramp
// - Flux kept for off-delay after stop
// - After ready, start needs zero position first
// - Slowdown limits remembered direction only
// - Slowdown at power-up or standstill: both
// - Split slowdown inputs limit each sign
// - Fast stop on falling edge while running
// - Fast stop clears after zero speed, neutral
// - Combined mode picks torque or speed control
// - References every 32 ms, trim every 8 ms
// - Slowdown in torque control forces speed
// - Unramped trim added to ramp output
// - Sum clamped to maximum and minimum speed
// - Health output low on listed faults
module crane_joystick_standalone_ctrl import crane_pkg::*; #(
  parameter int MS_CYC = `MS_CYC(`TICK_MS),
  parameter int REF_CYC = `MS_CYC(`REF_UPD_MS),
  parameter int TRIM_CYC = `MS_CYC(`TRIM_UPD_MS)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire joy_s joy,
  input wire logic slowdown_n,
  input wire logic slowdown_b_n,
  input wire logic fast_stop_n,
  input wire logic [11:0] speed_ain,
  input wire logic [11:0] analog_torque_command,
  input wire logic signed [11:0] unramped_velocity_trim,
  input wire vel_t ramp_out,
  input wire logic zero_speed,
  input wire logic flux_ready,
  input wire logic drive_ready,
  input wire fault_s faults,
  output logic start_cmd,
  output logic magnetise,
  output logic torque_mode,
  output logic stick_warning,
  output logic healthy,
  output fs_out_s fs_out,
  output vel_t speed_target,
  output vel_t torque_target,
  output vel_t speed_cmd
);

  if (MS_CYC < 1 || REF_CYC < MS_CYC || TRIM_CYC < MS_CYC || REF_CYC >= 2**23) begin : g_chk
    $error("crane ctrl: divider lengths out of range");
  end

  logic [31:0] ctrl, deadzone, aoffset, reduced, limits, trqmax, delays, fluxoff, fbtrim;
  run_state_e state, next_state;
  logic [2:0] tick;
  logic [3:0] tcond, tdone;
  logic [15:0] tlim [4];
  logic [15:0] spd_pct, trq_pct, mag;
  logic neutral, spd_hi, trq_hi, spd_hi_q, trq_hi_q, start_ok, running;
  logic armed, stick_fault, fs_active, fs_prev, zp_prev, zp_rise, slow_prev;
  logic mem_valid, mem_dir, lim_pos, lim_neg, we;
  vel_t next_spd, trim_val;
  logic signed [31:0] trim_sum, cmd_sum;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Analog code to hundredths of a percent, code at or below offset reads zero
  function automatic logic [15:0] ain_pct(input logic [11:0] v, input logic [11:0] off);
    logic [31:0] num;
    logic [31:0] den;
    num = (v > off) ? 32'(v - off) * `PCT_FULL : 32'h0;
    den = (off < `AIN_FULL) ? 32'(`AIN_FULL - off) : 32'h1;
    return 16'(num / den);
  endfunction : ain_pct

  // Blend linear, square and cubic curves by the shape setting
  function automatic logic [15:0] shape_curve(input logic [15:0] x, input logic [6:0] p);
    logic [31:0] sq;
    logic [31:0] cu;
    logic [31:0] r;
    logic [6:0] q;
    q = (p > `SHAPE_CU) ? `SHAPE_CU : p;
    sq = (32'(x) * 32'(x)) / `PCT_FULL;
    cu = (sq * 32'(x)) / `PCT_FULL;
    if (q <= `SHAPE_SQ) begin
      r = (32'(x) * 32'(`SHAPE_SQ - q) + sq * 32'(q)) / 32'(`SHAPE_SQ);
    end else begin
      r = (sq * 32'(`SHAPE_CU - q) + cu * 32'(q - `SHAPE_SQ)) / 32'(`SHAPE_CU - `SHAPE_SQ);
    end
    return 16'(r);
  endfunction : shape_curve

  // Address decode shared by the write and read channels
  function automatic logic reg_ok(input logic [7:0] a, input logic wr);
    return (a[1:0] == 2'h0) && (a <= (wr ? `OFS_FBTRIM : `OFS_REFS));
  endfunction : reg_ok

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    for (int i = 0; i < 4; i++) begin
      r[8*i +: 8] = s[i] ? d[8*i +: 8] : old[8*i +: 8];
    end
    return r;
  endfunction : merge

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  assign we = awvalid && wvalid && !awready && !bvalid;

  // Address and data are taken together; the response follows both handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else begin
      awready <= we;
      wready <= we;
      if (we) begin
        bresp <= reg_ok(awaddr, 1'b1) ? 2'h0 : 2'h2;
      end
      if (awready) begin
        bvalid <= 1'b1;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Writable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `RST_CTRL;
      deadzone <= `RST_DEADZONE;
      aoffset <= `RST_AOFFSET;
      reduced <= `RST_REDUCED;
      limits <= `RST_LIMITS;
      trqmax <= `RST_TRQMAX;
      delays <= `RST_DELAYS;
      fluxoff <= `RST_FLUXOFF;
      fbtrim <= `RST_FBTRIM;
    end else if (we) begin
      case (awaddr)
        `OFS_CTRL: ctrl <= merge(ctrl, wdata, wstrb);
        `OFS_DEADZONE: deadzone <= merge(deadzone, wdata, wstrb);
        `OFS_AOFFSET: aoffset <= merge(aoffset, wdata, wstrb) & 32'h00000FFF;
        `OFS_REDUCED: reduced <= merge(reduced, wdata, wstrb) & 32'h0000FFFF;
        `OFS_LIMITS: limits <= merge(limits, wdata, wstrb);
        `OFS_TRQMAX: trqmax <= merge(trqmax, wdata, wstrb) & 32'h0000FFFF;
        `OFS_DELAYS: delays <= merge(delays, wdata, wstrb);
        `OFS_FLUXOFF: fluxoff <= merge(fluxoff, wdata, wstrb) & 32'h0000FFFF;
        `OFS_FBTRIM: fbtrim <= merge(fbtrim, wdata, wstrb) & 32'h0000FFFF;
        default: ;
      endcase
    end
  end

  // Read channel; data are latched at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (arready) begin
        rvalid <= 1'b1;
        rresp <= reg_ok(araddr, 1'b0) ? 2'h0 : 2'h2;
        case (araddr)
          `OFS_CTRL: rdata <= ctrl;
          `OFS_DEADZONE: rdata <= deadzone;
          `OFS_AOFFSET: rdata <= aoffset;
          `OFS_REDUCED: rdata <= reduced;
          `OFS_LIMITS: rdata <= limits;
          `OFS_TRQMAX: rdata <= trqmax;
          `OFS_DELAYS: rdata <= delays;
          `OFS_FLUXOFF: rdata <= fluxoff;
          `OFS_FBTRIM: rdata <= fbtrim;
          `OFS_STATUS: rdata <= {20'h0, healthy, torque_mode, stick_fault, fs_active, armed,
                                 lim_neg, lim_pos, mem_valid, mem_dir, zp_rise, state};
          `OFS_REFS: rdata <= {torque_target, speed_target};
          default: rdata <= 32'h0;
        endcase
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Rate dividers and hold timers
  // ---------------------------------------------------------------
  localparam int DIV_LEN [3] = '{MS_CYC, REF_CYC, TRIM_CYC};

  // Millisecond, reference update and trim update enables
  for (genvar g = 0; g < 3; g++) begin : g_div
    logic [22:0] cnt;
    logic pulse;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt <= 23'h0;
        pulse <= 1'b0;
      end else begin
        pulse <= (cnt == 23'(DIV_LEN[g] - 1));
        cnt <= (cnt == 23'(DIV_LEN[g] - 1)) ? 23'h0 : cnt + 23'h1;
      end
    end
    assign tick[g] = pulse;
  end

  // Timers: stick fault, neutral hold, fast-stop release, flux off-delay
  assign tcond = {state == ST_OFFD, fs_active && zero_speed && zp_rise && joy.zero_pos,
                  neutral, (joy.dir_a && joy.dir_b) || (neutral && (spd_hi || trq_hi))};
  assign tlim = '{delays[15:0], delays[31:16], delays[31:16], fluxoff[15:0]};

  for (genvar t = 0; t < 4; t++) begin : g_tmr
    hold_timer #(.CNT_W(16)) u_tmr (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick[0]),
      .cond(tcond[t]),
      .limit(tlim[t]),
      .done(tdone[t])
    );
  end

  // ---------------------------------------------------------------
  // Reference path
  // ---------------------------------------------------------------
  always_comb begin
    spd_pct = ain_pct(speed_ain, aoffset[11:0]);
    trq_pct = ain_pct(analog_torque_command, 12'h000);
    neutral = joy.zero_pos && !joy.dir_a && !joy.dir_b;
    spd_hi = speed_ain > `AIN_1V;
    trq_hi = analog_torque_command > `AIN_2MA;
    running = state == ST_RUN;
    start_ok = ctrl[`F_SA] && armed && (joy.dir_a ^ joy.dir_b) && !joy.zero_pos
               && !stick_fault && !fs_active;
    mag = (spd_pct > (joy.dir_a ? deadzone[15:0] : deadzone[31:16]))
          ? shape_curve(spd_pct, ctrl[`F_SHAPE]) : 16'h0;
    next_spd = joy.dir_a ? vel_t'(mag) : -vel_t'(mag);
    if (lim_pos && next_spd > vel_t'(reduced[15:0])) begin
      next_spd = vel_t'(reduced[15:0]);
    end
    if (lim_neg && next_spd < -vel_t'(reduced[15:0])) begin
      next_spd = -vel_t'(reduced[15:0]);
    end
    trim_sum = ((32'(unramped_velocity_trim) * $signed(`PCT_FULL)) >>> `TRIM_SHIFT)
               + 32'(vel_t'(fbtrim[15:0]));
    cmd_sum = 32'(ramp_out) + 32'(trim_val);
  end

  // Slowdown direction memory; cleared by reset or by a slowdown edge at standstill
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slow_prev <= 1'b1;
      mem_valid <= 1'b0;
      mem_dir <= 1'b0;
    end else begin
      slow_prev <= slowdown_n;
      if (slow_prev && !slowdown_n) begin
        mem_valid <= !zero_speed;
        mem_dir <= ramp_out > 16'sh0000;
      end
    end
  end

  always_comb begin
    if (ctrl[`F_SPLIT]) begin
      lim_pos = !slowdown_n;
      lim_neg = !slowdown_b_n;
    end else begin
      lim_pos = !slowdown_n && (!mem_valid || mem_dir);
      lim_neg = !slowdown_n && (!mem_valid || !mem_dir);
    end
  end

  // Speed and torque references refresh on the slow tick only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_target <= 16'sh0000;
      torque_target <= 16'sh0000;
    end else if (tick[1]) begin
      speed_target <= (ctrl[`F_SA] && running && !torque_mode) ? next_spd : 16'sh0000;
      torque_target <= (ctrl[`F_SA] && running && torque_mode)
                       ? (joy.dir_a ? 16'sh0001 : -16'sh0001) * vel_t'((32'(trq_pct) * trqmax) / `PCT_FULL)
                       : 16'sh0000;
    end
  end

  // Trim bypasses the ramp; sum clamped to the speed window every cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trim_val <= 16'sh0000;
      speed_cmd <= 16'sh0000;
    end else begin
      if (tick[2]) begin
        trim_val <= vel_t'(trim_sum);
      end
      if (cmd_sum > 32'(vel_t'(limits[15:0]))) begin
        speed_cmd <= vel_t'(limits[15:0]);
      end else if (cmd_sum < 32'(vel_t'(limits[31:16]))) begin
        speed_cmd <= vel_t'(limits[31:16]);
      end else begin
        speed_cmd <= vel_t'(cmd_sum);
      end
    end
  end

  // ---------------------------------------------------------------
  // Interlocks, mode and sequencing
  // ---------------------------------------------------------------
  // Stick fault and fast stop latch; a new set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed <= 1'b0;
      stick_fault <= 1'b0;
      stick_warning <= 1'b0;
      fs_active <= 1'b0;
      fs_out <= '0;
      fs_prev <= 1'b1;
      zp_prev <= 1'b0;
      zp_rise <= 1'b0;
      healthy <= 1'b0;
    end else begin
      fs_prev <= fast_stop_n;
      zp_prev <= joy.zero_pos;
      healthy <= !(|faults);
      if (drive_ready && neutral) begin
        armed <= 1'b1;
      end
      if (tdone[0]) begin
        stick_fault <= 1'b1;
      end else if (tdone[1]) begin
        stick_fault <= 1'b0;
      end
      stick_warning <= tdone[0] || (stick_fault && !tdone[1]);
      if (!joy.zero_pos) begin
        zp_rise <= 1'b0;
      end else if (fs_active && !zp_prev) begin
        zp_rise <= 1'b1;
      end
      if (fs_prev && !fast_stop_n && running && ctrl[`F_SA]) begin
        fs_active <= 1'b1;
        fs_out.fast_zero_set <= ctrl[`F_FSTYPE] != FS_MECH;
        fs_out.speed_off <= ctrl[`F_FSTYPE] == FS_TLIM_MECH;
        fs_out.fast_stop <= ctrl[`F_FSTYPE] != FS_TLIM;
      end else if (tdone[2]) begin
        fs_active <= 1'b0;
        fs_out <= '0;
      end
    end
  end

  // Speed or torque regulation; a slowdown limit always wins for speed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      torque_mode <= 1'b0;
      spd_hi_q <= 1'b0;
      trq_hi_q <= 1'b0;
    end else begin
      spd_hi_q <= spd_hi;
      trq_hi_q <= trq_hi;
      if (lim_pos || lim_neg) begin
        torque_mode <= 1'b0;
      end else begin
        case (ctrl[`F_REGSEL])
          RM_SPEED: torque_mode <= 1'b0;
          RM_TORQ: torque_mode <= 1'b1;
          RM_COMB: begin
            if (spd_hi && !spd_hi_q) begin
              torque_mode <= 1'b0;
            end else if (trq_hi && !trq_hi_q && !spd_hi) begin
              torque_mode <= 1'b1;
            end
          end
          default: torque_mode <= 1'b0;
        endcase
      end
    end
  end

  // Run sequence: magnetise, run, then hold flux for the off-delay
  always_comb begin
    case (state)
      ST_IDLE: next_state = start_ok ? (flux_ready ? ST_RUN : ST_MAGN) : ST_IDLE;
      ST_MAGN: next_state = !start_ok ? ST_OFFD : (flux_ready ? ST_RUN : ST_MAGN);
      ST_RUN: next_state = start_ok ? ST_RUN : ST_OFFD;
      ST_OFFD: next_state = start_ok ? (flux_ready ? ST_RUN : ST_MAGN) : (tdone[3] ? ST_IDLE : ST_OFFD);
      default: next_state = ST_IDLE;
    endcase
    if (!ctrl[`F_SA]) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      start_cmd <= 1'b0;
      magnetise <= 1'b0;
    end else begin
      state <= next_state;
      start_cmd <= next_state == ST_RUN;
      magnetise <= next_state != ST_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_start_req;
    state == ST_IDLE && start_ok;
  endsequence
  sequence s_seq_entered;
    (state == ST_MAGN || state == ST_RUN) && magnetise;
  endsequence
  property p_start_seq;
    @(posedge aclk) disable iff (!aresetn) s_start_req |=> s_seq_entered;
  endproperty
  a_start_seq: assert property (p_start_seq) else $error("start did not magnetise");
  property p_sa_off;
    @(posedge aclk) disable iff (!aresetn) !ctrl[`F_SA] |-> ##1 (state == ST_IDLE && !start_cmd && !magnetise);
  endproperty
  a_sa_off: assert property (p_sa_off) else $error("ran without stand-alone selection");
  property p_not_armed;
    @(posedge aclk) disable iff (!aresetn) !armed |-> ##1 !start_cmd;
  endproperty
  a_not_armed: assert property (p_not_armed) else $error("start before zero position");
  property p_fault_stops;
    @(posedge aclk) disable iff (!aresetn) stick_fault ##1 stick_fault |-> !start_cmd [*2];
  endproperty
  a_fault_stops: assert property (p_fault_stops) else $error("run during joystick fault");
  property p_warn;
    @(posedge aclk) disable iff (!aresetn) $rose(stick_fault) |-> stick_warning;
  endproperty
  a_warn: assert property (p_warn) else $error("joystick fault without warning");
  property p_fs_trig;
    @(posedge aclk) disable iff (!aresetn)
      $fell(fast_stop_n) && running && ctrl[`F_SA] && !tdone[2] |=> fs_active && fs_out != 3'h0;
  endproperty
  a_fs_trig: assert property (p_fs_trig) else $error("fast stop not taken");
  property p_fs_hold;
    @(posedge aclk) disable iff (!aresetn) fs_active && !tdone[2] |=> fs_active;
  endproperty
  a_fs_hold: assert property (p_fs_hold) else $error("fast stop released early");
  property p_health;
    @(posedge aclk) disable iff (!aresetn) (|faults) |=> !healthy;
  endproperty
  a_health: assert property (p_health) else $error("healthy during fault");
  property p_clamp;
    @(posedge aclk) disable iff (!aresetn)
      $signed(limits[31:16]) <= $signed(limits[15:0]) |=> $stable(limits) |->
      ((speed_cmd <= vel_t'(limits[15:0])) && (speed_cmd >= vel_t'(limits[31:16])));
  endproperty
  a_clamp: assert property (p_clamp) else $error("speed command outside limits");

endmodule : crane_joystick_standalone_ctrl

// ### verification/stick_model.sv
// Operator joystick model for the crane control bench
`timescale 1ns/100ps
module stick_model import crane_pkg::*; (
  input wire logic aclk,
  input wire logic [1:0] pos,
  output joy_s joy
);
  // ----------
  // Contacts
  // ----------
  // Lever position 0 neutral, 1 A, 2 B, 3 both; contacts move after an edge
  initial joy = 3'h4;
  always @(posedge aclk) begin
    joy.zero_pos <= (pos == 2'h0);
    joy.dir_a <= pos[0];
    joy.dir_b <= pos[1];
  end
endmodule : stick_model

// ### verification/tb_top.sv
// Self-checking bench for the stand-alone crane joystick control
`timescale 1ns/100ps
`define CMP(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top import crane_pkg::*; ;
  // ----------
  // Signals
  // ----------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, start_cmd, magnetise, stick_warning, healthy;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, rr, pos = 2'h0;
  logic drive_ready = 1'b0, flux_ready = 1'b0, sd_n = 1'b1, zs = 1'b1, fs_n = 1'b1;
  logic [11:0] spd = 12'h000, trq = 12'h000, trim = 12'h000;
  vel_t ramp = 16'sh0000;
  fault_s faults = '0;
  joy_s joy;
  vel_t spd_tgt, trq_tgt, spd_cmd;
  logic tmode;
  fs_out_s fso;
  int failures = 0, check_count = 0;
  // Short ms tick keeps the delays within a brief run
  crane_joystick_standalone_ctrl #(.MS_CYC(4), .REF_CYC(16), .TRIM_CYC(8)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .joy(joy),
    .slowdown_n(sd_n), .slowdown_b_n(sd_n), .fast_stop_n(fs_n), .speed_ain(spd),
    .analog_torque_command(trq), .unramped_velocity_trim(trim), .ramp_out(ramp),
    .zero_speed(zs), .flux_ready(flux_ready), .drive_ready(drive_ready), .faults(faults),
    .start_cmd(start_cmd), .magnetise(magnetise), .torque_mode(tmode), .stick_warning(stick_warning),
    .healthy(healthy), .fs_out(fso), .speed_target(spd_tgt), .torque_target(trq_tgt), .speed_cmd(spd_cmd));
  stick_model u_stick (.aclk(aclk), .pos(pos), .joy(joy));
  always #20 aclk = ~aclk;
  // ----------
  // Bus tasks
  // ----------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    @(posedge aclk);
    while (awready !== 1'b1) @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    @(posedge aclk);
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    @(posedge aclk);
    while (arready !== 1'b1) @(posedge aclk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    @(posedge aclk);
    while (rvalid !== 1'b1) @(posedge aclk);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  // ----------
  // Scenarios
  // ----------
  task automatic t_regs;
    axi_rd(8'h00);
    `CMP(rd, 32'h00000010)
    axi_rd(8'h30);
    `CMP(rr, 2'h2)
  endtask : t_regs
  // Ready only after the lever left neutral, so no arming happens here
  task automatic t_no_sa;
    pos <= 2'h1;
    flux_ready <= 1'b1;
    repeat (3) @(posedge aclk);
    drive_ready <= 1'b1;
    repeat (30) @(posedge aclk);
    `CMP(start_cmd, 1'b0)
    `CMP(magnetise, 1'b0)
  endtask : t_no_sa
  task automatic t_start;
    axi_wr(8'h00, 32'h00000011);
    repeat (30) @(posedge aclk);
    `CMP(start_cmd, 1'b0)
    pos <= 2'h0;
    repeat (10) @(posedge aclk);
    pos <= 2'h1;
    repeat (40) if (start_cmd !== 1'b1) @(posedge aclk);
    `CMP(start_cmd, 1'b1)
    `CMP(magnetise, 1'b1)
    pos <= 2'h0;
    repeat (10) @(posedge aclk);
    `CMP(start_cmd, 1'b0)
    `CMP(magnetise, 1'b1)
  endtask : t_start
  task automatic t_stick;
    axi_wr(8'h18, 32'h00030005);
    pos <= 2'h3;
    repeat (60) @(posedge aclk);
    `CMP(stick_warning, 1'b1)
    pos <= 2'h1;
    repeat (30) @(posedge aclk);
    `CMP(start_cmd, 1'b0)
    pos <= 2'h0;
    repeat (40) @(posedge aclk);
    pos <= 2'h1;
    repeat (40) if (start_cmd !== 1'b1) @(posedge aclk);
    `CMP(start_cmd, 1'b1)
  endtask : t_stick
  task automatic t_health;
    for (int i = 0; i < 5; i++) begin
      faults <= fault_s'(5'h01 << i);
      repeat (3) @(posedge aclk);
      `CMP(healthy, 1'b0)
      faults <= '0;
      repeat (3) @(posedge aclk);
      `CMP(healthy, 1'b1)
    end
  endtask : t_health
  // Runs in direction A: full-scale references, unramped trim, clamp, slowdown
  task automatic t_ref;
    spd <= 12'hFFF;
    repeat (40) @(posedge aclk);
    `CMP(spd_tgt, 16'h2710)
    ramp <= 16'sh0100;
    trim <= 12'h800;
    repeat (20) @(posedge aclk);
    `CMP(spd_cmd, 16'hD9F0)
    ramp <= -16'sh1000;
    repeat (3) @(posedge aclk);
    `CMP(spd_cmd, 16'hD8F0)
    axi_wr(8'h00, 32'h00000015);
    trq <= 12'hFFF;
    repeat (40) @(posedge aclk);
    `CMP(tmode, 1'b1)
    `CMP(trq_tgt, 16'h2710)
    sd_n <= 1'b0;
    repeat (40) @(posedge aclk);
    `CMP(tmode, 1'b0)
    `CMP(spd_tgt, 16'h07D0)
    sd_n <= 1'b1;
  endtask : t_ref
  // Type 1 fast stop, then release through neutral; analog left high in neutral
  task automatic t_fast;
    fs_n <= 1'b0;
    repeat (3) @(posedge aclk);
    `CMP(fso, 3'h4)
    `CMP(start_cmd, 1'b0)
    fs_n <= 1'b1;
    pos <= 2'h0;
    repeat (40) @(posedge aclk);
    `CMP(fso, 3'h0)
    `CMP(stick_warning, 1'b1)
  endtask : t_fast
  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // Run is a few hundred cycles; the limit allows a wide margin
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_no_sa();
    t_start();
    t_stick();
    t_health();
    t_ref();
    t_fast();
    report_and_stop();
  end
endmodule : tb_top
